// >>> design/cmst_core.v
// Common command interpreter with status masks and four saved slots.
// Assumes a single AHB-Lite master with word transfers and a pending flag input.
//
// Contract
// R1 - Option query returns option string or zero
// R2 - Power-on clear zeroes both masks when set
// R3 - Power-on clear defaults to enabled
// R4 - Host saves slot zero after changing setting
// R5 - Power-on clear query returns character 0/1
// R6 - Four slots; recall restores saved config
// R7 - Recall of empty slot queues error 810
// R8 - Reset restores defaults, aborts pending work
// R9 - Reset keeps queue, masks, calibration
// R10 - Save captures function, frequency, levels, modulation
// R11 - Power-up restores slot zero
// R12 - Volatile waveform not saved; nonvolatile saved
// R13 - Deleted waveform recalls as builtin_sin_x_over_x_wave
// R14 - Eight-bit mask gates service request only
// R15 - Mask empty at power-up, kept on reset
// R16 - Mask query returns weighted sum
// R17 - Status byte bit six flags request
// R18 - Bus trigger only with bus source
// R19 - Self-test returns zero or failure, logs
// R20 - Self-test leaves settings unchanged
// R21 - Host avoids device clear during self-test
// R22 - Wait holds later commands until idle
// R23 - Auto recall makes power-on differ
// R24 - Valid flag per slot checked before recall
// R25 - Operation complete sets event bit zero
`timescale 1ns/1ns
`include "cmst_defs.vh"
module cmst_core #(
    parameter OPT_FITTED = 1,
    parameter NSLOT      = 4
) (
    input  wire        i_ref_clk,
    input  wire        i_reset_n,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    input  wire        i_pending,
    input  wire        i_wave_deleted,
    input  wire        i_tst_fail,
    output reg         o_trigger,
    output reg         o_abort,
    output reg         o_srq
);
    // ************************************************
    // Bus address phase capture
    // ************************************************
    reg        ap_valid;
    reg        ap_write;
    reg [7:0]  ap_addr;
    wire       ap_take = i_hsel & i_hready & i_htrans[1];
    // Live output settings
    reg [3:0]  func;
    reg [31:0] freq;
    reg [31:0] ampl;
    reg [31:0] offs;
    reg [31:0] duty;
    reg [31:0] modp;
    // Trigger source and run mode
    reg [1:0]  trig_src;
    reg [1:0]  run_mode;
    // Stored slot contents
    reg [3:0]  s_func [0:NSLOT-1];
    reg [31:0] s_freq [0:NSLOT-1];
    reg [31:0] s_ampl [0:NSLOT-1];
    reg [31:0] s_offs [0:NSLOT-1];
    reg [31:0] s_duty [0:NSLOT-1];
    reg [31:0] s_modp [0:NSLOT-1];
    reg        s_psc  [0:NSLOT-1];
    // One valid flag per slot
    reg [NSLOT-1:0] slot_valid;
    reg        auto_recall;
    reg        psc;
    // Status, event and enable bytes
    reg [7:0]  sre;
    reg [7:0]  ese;
    reg [7:0]  esr;
    reg [7:0]  stb_ev;
    // Answer, argument and error queue head
    reg [31:0] resp;
    reg [31:0] arg;
    reg [31:0] err;
    // Queue flag and wait flags
    reg        err_valid;
    reg        opc_wait;
    reg        wai_wait;
    // Held command and self-test count
    reg [3:0]  cmd_hold;
    reg [3:0]  tst_cnt;
    // Slot named by the argument
    wire [1:0] slot = arg[1:0];
    // Recall uses the argument, power-up slot zero
    wire [1:0] rcl_slot = (cmd_hold == `CMST_CMD_RCL) ? slot : 2'h0;
    wire       srq_now = |(stb_ev & sre & 8'hBF);
    wire [7:0] stb = {stb_ev[7], srq_now, stb_ev[5:0]};  // R17
    integer    k;

    // ************************************************
    // Read multiplexer
    // ************************************************
    reg [31:0] rd;
    always @* begin
        case (ap_addr)
            `CMST_REG_RESP: rd = resp;
            `CMST_REG_STAT: rd = {24'h0, auto_recall, tst_cnt != 4'h0, wai_wait,
                                  opc_wait, slot_valid};
            `CMST_REG_SRE:  rd = {24'h0, sre};                     // R16
            `CMST_REG_ESE:  rd = {24'h0, ese};
            `CMST_REG_STB:  rd = {24'h0, stb};                     // R17
            `CMST_REG_ESR:  rd = {24'h0, esr};
            `CMST_REG_FUNC: rd = {28'h0, func};
            `CMST_REG_FREQ: rd = freq;
            `CMST_REG_AMPL: rd = ampl;
            `CMST_REG_OFFS: rd = offs;
            `CMST_REG_DUTY: rd = duty;
            `CMST_REG_MODP: rd = {26'h0, trig_src, run_mode, modp[1:0]};
            `CMST_REG_ERR:  rd = {err_valid, err[30:0]};
            default:        rd = 32'h0;
        endcase
    end

    // ************************************************
    // Bus slave and command engine
    // ************************************************
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Bus side idle, no wait state
            ap_valid    <= 1'b0;
            ap_write    <= 1'b0;
            ap_addr     <= 8'h00;
            o_hrdata    <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            // Pulses and request low
            o_trigger   <= 1'b0;
            o_abort     <= 1'b0;
            o_srq       <= 1'b0;
            // Power-on output settings
            func        <= `CMST_FUNC_SINE;
            freq        <= `CMST_DEF_FREQ;
            ampl        <= `CMST_DEF_AMPL;
            offs        <= `CMST_DEF_OFFS;
            duty        <= `CMST_DEF_DUTY;
            modp        <= `CMST_DEF_MODP;
            trig_src    <= 2'h0;
            run_mode    <= 2'h0;
            // No slot saved yet, auto recall off
            slot_valid  <= {NSLOT{1'b0}};
            auto_recall <= 1'b0;
            psc         <= 1'b1;                                  // R3
            // Masks empty at power-up
            sre         <= 8'h00;                                 // R15
            ese         <= 8'h00;
            esr         <= 8'h00;
            stb_ev      <= 8'h00;
            // Answer and error queue empty
            resp        <= 32'h0;
            arg         <= 32'h0;
            err         <= 32'h0;
            err_valid   <= 1'b0;
            // Nothing waiting or running
            opc_wait    <= 1'b0;
            wai_wait    <= 1'b0;
            cmd_hold    <= 4'h0;
            tst_cnt     <= 4'h0;
            // Slot contents cleared
            for (k = 0; k < NSLOT; k = k + 1) begin
                s_func[k] <= `CMST_FUNC_SINE;
                s_freq[k] <= 32'h0;
                s_ampl[k] <= 32'h0;
                s_offs[k] <= 32'h0;
                s_duty[k] <= 32'h0;
                s_modp[k] <= 32'h0;
                s_psc[k]  <= 1'b1;
            end
        end else begin
            o_trigger <= 1'b0;
            o_abort <= 1'b0;
            o_srq <= srq_now;                                     // R14
            o_hreadyout <= 1'b1;
            // Reads take one wait state for registered data
            if (ap_take && !i_hwrite)
                o_hreadyout <= 1'b0;
            if (i_hready) begin
                ap_valid <= ap_take;
                ap_write <= i_hwrite;
                ap_addr <= i_haddr[7:0];
            end
            // Read wait cycle registers data; write data phase applies
            if (ap_valid && !ap_write && !o_hreadyout) begin
                o_hrdata <= rd;
                if (ap_addr == `CMST_REG_ESR)
                    esr <= 8'h00;
                if (ap_addr == `CMST_REG_ERR)
                    err_valid <= 1'b0;
            end
            if (ap_valid && ap_write) begin
                case (ap_addr)
                    `CMST_REG_ARG:  arg <= i_hwdata;
                    `CMST_REG_ESE:  ese <= i_hwdata[7:0];
                    `CMST_REG_STB:  stb_ev <= i_hwdata[7:0];
                    `CMST_REG_FUNC: func <= i_hwdata[3:0];
                    `CMST_REG_FREQ: freq <= i_hwdata;
                    `CMST_REG_AMPL: ampl <= i_hwdata;
                    `CMST_REG_OFFS: offs <= i_hwdata;
                    `CMST_REG_DUTY: duty <= i_hwdata;
                    `CMST_REG_MODP: begin
                        trig_src <= i_hwdata[5:4];
                        run_mode <= i_hwdata[3:2];
                        auto_recall <= i_hwdata[8];
                    end
                    `CMST_REG_CMD: cmd_hold <= i_hwdata[3:0];
                    default: ;
                endcase
            end
            // Self-test runs on no setting; counts down, then sets answer, and error on failure
            if (tst_cnt != 4'h0) begin
                tst_cnt <= tst_cnt - 4'h1;                        // R20
                if (tst_cnt == 4'h1) begin
                    resp <= {31'h0, i_tst_fail};                  // R19
                    if (i_tst_fail) begin
                        err <= 32'h0000_0001;
                        err_valid <= 1'b1;
                    end
                end
            end
            // Operation complete after pending work ends
            if (opc_wait && !i_pending) begin
                esr[`CMST_ESR_OPC_BIT] <= 1'b1;                   // R25
                opc_wait <= 1'b0;
            end
            if (wai_wait && !i_pending)
                wai_wait <= 1'b0;                                 // R22
            // Execute held command when not waiting and no self-test runs
            if (cmd_hold != 4'h0 && !wai_wait && tst_cnt == 4'h0) begin  // R22
                cmd_hold <= 4'h0;
                case (cmd_hold)
                    // Option string or a single zero
                    `CMST_CMD_OPT:
                        resp <= (OPT_FITTED != 0) ? {`CMST_RESP_PLL_HI, 24'h3A504C}
                                                  : {24'h0, `CMST_CHAR_0};  // R1
                    // Power-on clear setting and its query
                    `CMST_CMD_PSC:  psc <= arg[0];
                    `CMST_CMD_PSCQ: resp <= {24'h0, psc ? `CMST_CHAR_1
                                                        : `CMST_CHAR_0};  // R5
                    // Service mask write and query
                    `CMST_CMD_SRE:  sre <= arg[7:0];                      // R14
                    `CMST_CMD_SREQ: resp <= {24'h0, sre};                 // R16
                    // Status byte with request bit
                    `CMST_CMD_STB:  resp <= {24'h0, stb};                 // R17
                    // Trigger only from bus source, in burst or sweep
                    `CMST_CMD_TRG:
                        if (trig_src == `CMST_TRIG_BUS &&
                            (run_mode == `CMST_MODE_BURST ||
                             run_mode == `CMST_MODE_SWEEP))
                            o_trigger <= 1'b1;                            // R18
                    // Self-test count, settings untouched
                    `CMST_CMD_TST:  tst_cnt <= `CMST_TST_CYCLES;          // R19
                    // Hold later commands while work pends
                    `CMST_CMD_WAI:  wai_wait <= i_pending;                // R22
                    // Flag event bit once work ends
                    `CMST_CMD_OPC:  opc_wait <= 1'b1;                     // R25
                    `CMST_CMD_RST: begin
                        // Masks, queue and calibration stay as they are
                        func     <= `CMST_FUNC_SINE;                      // R8
                        freq     <= `CMST_DEF_FREQ;
                        ampl     <= `CMST_DEF_AMPL;
                        offs     <= `CMST_DEF_OFFS;
                        duty     <= `CMST_DEF_DUTY;
                        modp     <= `CMST_DEF_MODP;
                        trig_src <= 2'h0;
                        run_mode <= 2'h0;
                        // Pending work is dropped
                        opc_wait <= 1'b0;
                        o_abort  <= 1'b1;                                 // R8
                    end
                    `CMST_CMD_SAV: begin
                        // Volatile waveform is not kept
                        s_func[slot] <= (func == `CMST_FUNC_ARB_VOL)
                                        ? `CMST_FUNC_SINE : func;         // R12
                        s_freq[slot] <= freq;                             // R10
                        s_ampl[slot] <= ampl;
                        s_offs[slot] <= offs;
                        s_duty[slot] <= duty;
                        s_modp[slot] <= modp;
                        s_psc[slot]  <= psc;
                        slot_valid[slot] <= 1'b1;                         // R24
                    end
                    `CMST_CMD_RCL, `CMST_CMD_POWERUP: begin
                        // Power-up clears masks only with the setting on
                        if (cmd_hold == `CMST_CMD_POWERUP && psc) begin
                            sre <= 8'h00;                                 // R2
                            ese <= 8'h00;
                        end
                        // Power-up without auto recall leaves settings as they are
                        if (cmd_hold == `CMST_CMD_POWERUP && !auto_recall) begin
                        end else if (slot_valid[rcl_slot]) begin          // R24
                            // R6 R11 R23
                            // Deleted stored waveform falls back
                            if (s_func[rcl_slot] == `CMST_FUNC_ARB_NV && i_wave_deleted)
                                func <= `CMST_FUNC_BUILTIN_SIN_X_OVER_X_WAVE;                  // R13
                            else
                                func <= s_func[rcl_slot];
                            freq <= s_freq[rcl_slot];
                            ampl <= s_ampl[rcl_slot];
                            offs <= s_offs[rcl_slot];
                            duty <= s_duty[rcl_slot];
                            modp <= s_modp[rcl_slot];
                            psc  <= s_psc[rcl_slot];
                        end else if (cmd_hold == `CMST_CMD_RCL) begin
                            // Empty slot refused, error queued
                            err       <= {16'h0, `CMST_ERR_NOSTATE};      // R7
                            err_valid <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// >>> design/cmst_defs.vh
// Constants for the common command status and state store block.
// Assumes inclusion by bare name from design files.
`ifndef CMST_DEFS_VH
`define CMST_DEFS_VH
// Register byte offsets
`define CMST_REG_CMD      8'h00
`define CMST_REG_ARG      8'h04
`define CMST_REG_RESP     8'h08
`define CMST_REG_STAT     8'h0C
`define CMST_REG_SRE      8'h10
`define CMST_REG_ESE      8'h14
`define CMST_REG_STB      8'h18
`define CMST_REG_ESR      8'h1C
`define CMST_REG_FUNC     8'h20
`define CMST_REG_FREQ     8'h24
`define CMST_REG_AMPL     8'h28
`define CMST_REG_OFFS     8'h2C
`define CMST_REG_DUTY     8'h30
`define CMST_REG_MODP     8'h34
`define CMST_REG_ERR      8'h38
// Command codes
`define CMST_CMD_OPT      4'h1
`define CMST_CMD_PSC      4'h2
`define CMST_CMD_PSCQ     4'h3
`define CMST_CMD_RCL      4'h4
`define CMST_CMD_RST      4'h5
`define CMST_CMD_SAV      4'h6
`define CMST_CMD_SRE      4'h7
`define CMST_CMD_SREQ     4'h8
`define CMST_CMD_STB      4'h9
`define CMST_CMD_TRG      4'hA
`define CMST_CMD_TST      4'hB
`define CMST_CMD_WAI      4'hC
`define CMST_CMD_OPC      4'hD
`define CMST_CMD_POWERUP  4'hE
// Responses and codes
`define CMST_RESP_PLL     32'h3A504C4C
`define CMST_RESP_PLL_HI  8'h31
`define CMST_CHAR_0       8'h30
`define CMST_CHAR_1       8'h31
`define CMST_ERR_NOSTATE  16'h032A
`define CMST_STB_RQS_BIT  6
`define CMST_ESR_OPC_BIT  0
// Function codes and defaults
`define CMST_FUNC_SINE    4'h0
`define CMST_FUNC_ARB_NV  4'h5
`define CMST_FUNC_ARB_VOL 4'h6
`define CMST_FUNC_BUILTIN_SIN_X_OVER_X_WAVE    4'h7
`define CMST_DEF_FREQ     32'h000003E8
`define CMST_DEF_AMPL     32'h00000064
`define CMST_DEF_OFFS     32'h00000000
`define CMST_DEF_DUTY     32'h00000032
`define CMST_DEF_MODP     32'h00000000
`define CMST_TRIG_BUS     2'h1
`define CMST_MODE_BURST   2'h1
`define CMST_MODE_SWEEP   2'h2
`define CMST_TST_CYCLES   4'h8
`endif

// >>> verif/cmst_core_chk.sv
// Checker for the command store: bus answer and pulse outputs.
// Assumes binding to cmst_core and sees its ports only.
`timescale 1ns/1ns
`include "cmst_defs.vh"
module cmst_core_chk (
    input wire        i_ref_clk,
    input wire        i_reset_n,
    input wire        i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire [31:0] i_hwdata,
    input wire        i_hready,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire        o_trigger,
    input wire        o_abort,
    input wire        o_srq
);
    // ****************************************
    // Command tracking and properties
    // ****************************************
    logic       ap_cmd;
    logic [2:0] rst_win;
    logic [2:0] trg_win;
    wire        cmd_dp = ap_cmd && i_hready;
    wire        rst_dp = cmd_dp && i_hwdata[3:0] == `CMST_CMD_RST;
    wire        trg_dp = cmd_dp && i_hwdata[3:0] == `CMST_CMD_TRG;
    // Command address phase, then short windows after reset and trigger commands
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ap_cmd  <= 1'b0;
            rst_win <= 3'h0;
            trg_win <= 3'h0;
        end else begin
            if (i_hready)
                ap_cmd <= i_hsel && i_htrans[1] && i_hwrite && i_haddr[7:0] == `CMST_REG_CMD;
            rst_win <= rst_dp ? 3'h6 : rst_win - {2'h0, rst_win != 3'h0};
            trg_win <= trg_dp ? 3'h6 : trg_win - {2'h0, trg_win != 3'h0};
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    a_ready_high: assert property (!o_hreadyout |=> o_hreadyout) else $error("long wait");
    a_resp_okay: assert property (!o_hresp) else $error("error response");
    a_trig_pulse: assert property (o_trigger |=> !o_trigger) else $error("trigger held");
    a_trig_cause: assert property (o_trigger |-> trg_win != 3'h0) else $error("stray trigger");
    a_abort_pulse: assert property (o_abort |=> !o_abort) else $error("abort held");
    a_abort_follow: assert property (rst_dp |-> ##[1:4] o_abort) else $error("no abort");
    a_abort_cause: assert property (o_abort |-> rst_win != 3'h0) else $error("stray abort");
    a_srq_poweron: assert property ($rose(i_reset_n) |-> !o_srq) else $error("srq at start");
    c_trigger: cover property (o_trigger);
    c_abort: cover property (o_abort);
    c_srq: cover property (o_srq);
endmodule
bind cmst_core cmst_core_chk u_chk (.i_ref_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_trigger, .o_abort, .o_srq);

// >>> verif/cmst_host.sv
// Host controller model: single word bus master and command issue.
// Assumes one slave that may stretch a transfer with wait states.
`timescale 1ns/1ns
`include "cmst_defs.vh"
module cmst_host (
    input  wire         i_ref_clk,
    input  wire         i_hready,
    input  wire  [31:0] i_hrdata,
    output logic        o_hsel   = 1'b0,
    output logic [31:0] o_haddr  = 32'h0,
    output logic [1:0]  o_htrans = 2'h0,
    output logic        o_hwrite = 1'b0,
    output logic [2:0]  o_hsize  = 3'h2,
    output logic [31:0] o_hwdata = 32'h0
);
    // ****************************************
    // Bus tasks
    // ****************************************
    // One transfer; released write data turns to its inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        o_haddr  <= {24'h0, a};
        o_hsel   <= 1'b1;
        o_htrans <= 2'h2;
        o_hwrite <= w;
        @(posedge i_ref_clk);
        while (i_hready !== 1'b1) @(posedge i_ref_clk);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        @(posedge i_ref_clk);
        while (i_hready !== 1'b1) @(posedge i_ref_clk);
        o_hwdata <= ~d;
        q = i_hrdata;
    endtask
    // Argument, command, then poll until no wait or self-test is busy
    task automatic cmd(input logic [3:0] c, input logic [31:0] a);
        logic [31:0] q;
        int          n;
        xfer(1'b1, `CMST_REG_ARG, a, q);
        xfer(1'b1, `CMST_REG_CMD, {28'h0, c}, q);
        n = 0;
        q = 32'hFF;
        while (q[6:4] !== 3'h0 && n < 200) begin
            xfer(1'b0, `CMST_REG_STAT, 32'h0, q);
            n++;
        end
    endtask
endmodule

// >>> verif/tb_top.sv
// Bench top: command rows, then trigger, status, test, wait, deleted wave and reset.
// Assumes the core, its checker bind and the host model.
`timescale 1ns/1ns
`include "cmst_defs.vh"
module tb_top;
    typedef struct {
        logic [3:0]  c;
        logic [31:0] a;
        logic [7:0]  r;
        logic [31:0] e;
        logic [31:0] m;
    } cmst_row_t;
    localparam int NROW = 22;
    logic        i_ref_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        pending   = 1'b0;
    logic        wave_del  = 1'b0;
    logic        tst_fail  = 1'b0;
    wire         hsel, hwrite, hreadyout, hresp, trigger, abort, srq;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n_trig = 0;
    int          k;
    logic [31:0] q;
    logic [31:0] tmodp [4] = '{32'h14, 32'h04, 32'h18, 32'h10};
    logic [31:0] texp [4] = '{32'h1, 32'h0, 32'h1, 32'h0};
    cmst_row_t   rows [NROW] = '{
        '{4'h0, 32'h0, `CMST_REG_STAT, 32'h0, 32'hF},
        '{`CMST_CMD_PSCQ, 32'h0, `CMST_REG_RESP, 32'h31, 32'hFF},
        '{4'h0, 32'h0, `CMST_REG_SRE, 32'h0, 32'hFF},
        '{`CMST_CMD_OPT, 32'h0, `CMST_REG_RESP, 32'h313A504C, 32'hFFFFFFFF},
        '{`CMST_CMD_SRE, 32'hA5, `CMST_REG_SRE, 32'hA5, 32'hFF},
        '{`CMST_CMD_RCL, 32'h3, `CMST_REG_ERR, 32'h8000032A, 32'h8000FFFF},
        '{4'h0, 32'h1234, `CMST_REG_FREQ, 32'h0, 32'h0},
        '{`CMST_CMD_SAV, 32'h2, `CMST_REG_STAT, 32'h4, 32'h4},
        '{4'h0, 32'h55, `CMST_REG_FREQ, 32'h0, 32'h0},
        '{`CMST_CMD_RCL, 32'h2, `CMST_REG_FREQ, 32'h1234, 32'hFFFFFFFF},
        '{`CMST_CMD_RST, 32'h0, `CMST_REG_FREQ, `CMST_DEF_FREQ, 32'hFFFFFFFF},
        '{4'h0, 32'h0, `CMST_REG_SRE, 32'hA5, 32'hFF},
        '{`CMST_CMD_OPC, 32'h0, `CMST_REG_ESR, 32'h1, 32'h1},
        '{`CMST_CMD_PSC, 32'h0, 8'h0, 32'h0, 32'h0},
        '{`CMST_CMD_PSCQ, 32'h0, `CMST_REG_RESP, 32'h30, 32'hFF},
        '{4'h0, 32'h777, `CMST_REG_FREQ, 32'h0, 32'h0},
        '{4'h0, 32'h100, `CMST_REG_MODP, 32'h0, 32'h0},
        '{`CMST_CMD_SAV, 32'h0, `CMST_REG_STAT, 32'h1, 32'h1},
        '{`CMST_CMD_POWERUP, 32'h0, `CMST_REG_FREQ, 32'h777, 32'hFFFFFFFF},
        '{4'h0, 32'h0, `CMST_REG_SRE, 32'hA5, 32'hFF},
        '{`CMST_CMD_PSC, 32'h1, 8'h0, 32'h0, 32'h0},
        '{`CMST_CMD_POWERUP, 32'h0, `CMST_REG_SRE, 32'h0, 32'hFF}};
    // ****************************************
    // Design, host, checks and run
    // ****************************************
    cmst_core #(.OPT_FITTED(1), .NSLOT(4)) dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .i_pending(pending), .i_wave_deleted(wave_del),
        .i_tst_fail(tst_fail), .o_trigger(trigger), .o_abort(abort), .o_srq(srq));
    cmst_host u_host (.i_ref_clk(i_ref_clk), .i_hready(hreadyout), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hsize(hsize), .o_hwdata(hwdata));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            $display("Error at %0t: seen %h expected %h", $time, s, e);
            n_mismatch++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial forever #5 i_ref_clk = ~i_ref_clk;
    // Timeout and trigger pulse count
    always @(posedge i_ref_clk) begin
        cycles++;
        if (trigger === 1'b1) n_trig++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(posedge i_ref_clk);
        for (int i = 0; i < NROW; i++) begin
            if (rows[i].c != 4'h0) u_host.cmd(rows[i].c, rows[i].a);
            else if (rows[i].m == 32'h0) u_host.xfer(1'b1, rows[i].r, rows[i].a, q);
            if (rows[i].m != 32'h0) begin
                u_host.xfer(1'b0, rows[i].r, 32'h0, q);
                chk(q & rows[i].m, rows[i].e);
            end
        end
        $display("command rows done");
        for (int i = 0; i < 4; i++) begin
            k = n_trig;
            u_host.xfer(1'b1, `CMST_REG_MODP, tmodp[i], q);
            u_host.cmd(`CMST_CMD_TRG, 32'h0);
            chk(32'(n_trig - k), texp[i]);
        end
        $display("trigger done");
        u_host.cmd(`CMST_CMD_SRE, 32'h1);
        u_host.xfer(1'b1, `CMST_REG_STB, 32'h1, q);
        u_host.xfer(1'b0, `CMST_REG_STB, 32'h0, q);
        chk({30'h0, q[6], srq}, 32'h3);
        u_host.cmd(`CMST_CMD_SRE, 32'h0);
        u_host.xfer(1'b0, `CMST_REG_STB, 32'h0, q);
        chk({29'h0, q[6], q[0], srq}, 32'h2);
        $display("status byte done");
        tst_fail <= 1'b1;
        u_host.cmd(`CMST_CMD_TST, 32'h0);
        u_host.xfer(1'b0, `CMST_REG_RESP, 32'h0, q);
        chk({31'h0, q != 32'h0}, 32'h1);
        u_host.xfer(1'b0, `CMST_REG_ERR, 32'h0, q);
        chk({31'h0, q[31]}, 32'h1);
        u_host.xfer(1'b0, `CMST_REG_FREQ, 32'h0, q);
        chk(q, 32'h777);
        tst_fail <= 1'b0;
        u_host.cmd(`CMST_CMD_TST, 32'h0);
        u_host.xfer(1'b0, `CMST_REG_RESP, 32'h0, q);
        chk(q, 32'h0);
        $display("self-test done");
        pending <= 1'b1;
        u_host.xfer(1'b1, `CMST_REG_CMD, {28'h0, `CMST_CMD_WAI}, q);
        u_host.xfer(1'b1, `CMST_REG_ARG, 32'h1, q);
        u_host.xfer(1'b1, `CMST_REG_CMD, {28'h0, `CMST_CMD_SAV}, q);
        repeat (10) @(posedge i_ref_clk);
        u_host.xfer(1'b0, `CMST_REG_STAT, 32'h0, q);
        chk({31'h0, q[1]}, 32'h0);
        pending <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        u_host.xfer(1'b0, `CMST_REG_STAT, 32'h0, q);
        chk({31'h0, q[1]}, 32'h1);
        $display("wait done");
        u_host.xfer(1'b1, `CMST_REG_FUNC, {28'h0, `CMST_FUNC_ARB_NV}, q);
        u_host.cmd(`CMST_CMD_SAV, 32'h3);
        wave_del <= 1'b1;
        u_host.cmd(`CMST_CMD_RCL, 32'h3);
        u_host.xfer(1'b0, `CMST_REG_FUNC, 32'h0, q);
        chk(q & 32'hF, {28'h0, `CMST_FUNC_BUILTIN_SIN_X_OVER_X_WAVE});
        wave_del <= 1'b0;
        u_host.xfer(1'b1, `CMST_REG_FUNC, {28'h0, `CMST_FUNC_ARB_VOL}, q);
        u_host.cmd(`CMST_CMD_SAV, 32'h1);
        u_host.cmd(`CMST_CMD_RCL, 32'h1);
        u_host.xfer(1'b0, `CMST_REG_FUNC, 32'h0, q);
        chk(q & 32'hF, {28'h0, `CMST_FUNC_SINE});
        $display("deleted wave done");
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(posedge i_ref_clk);
        u_host.xfer(1'b0, `CMST_REG_STAT, 32'h0, q);
        chk(q & 32'hF, 32'h0);
        u_host.xfer(1'b0, `CMST_REG_SRE, 32'h0, q);
        chk(q & 32'hFF, 32'h0);
        $display("reset done");
        finish_test();
    end
endmodule
